// ==== rtl/odt_termination_control.sv ====
`timescale 1ns/10ps
`include "odt_params.svh"

module odt_termination_control (
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Device side
  input wire logic odt_pin,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic burst_chop,
  input wire logic self_refresh,
  input wire logic dll_locked,
  output odt_pkg::term_state_e term_state,
  output odt_pkg::rtt_code_t rtt_code,
  output logic term_hiz,
  output logic odt_rx_enable
);

  // ========================================================
  // Functions
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Write latency minus the preamble-dependent offset
  function automatic odt_pkg::latency_t wl_minus(
    input logic [4:0] cwl_f,
    input logic [4:0] al_f,
    input logic [3:0] pl_f,
    input logic pre2
  );
    logic [6:0] sum;
    logic [6:0] off;
    sum = {2'h0, cwl_f} + {2'h0, al_f} + {3'h0, pl_f};
    off = {1'h0, pre2 ? `ODT_X_PRE2 : `ODT_X_PRE1};
    if (sum <= off + 7'h01) begin
      return 6'h01;
    end
    return 6'((sum - off) > 7'h3F ? 7'h3F : (sum - off));
  endfunction

  // ========================================================
  // Registers
  logic [31:0] mode1_reg;
  logic [31:0] mode2_reg;
  logic [31:0] mode5_reg;
  logic [31:0] lat_reg;
  logic ack_reg;

  odt_pkg::rtt_code_t nom_f;
  odt_pkg::rtt_code_t wr_f;
  odt_pkg::rtt_code_t park_f;
  logic [4:0] cwl_f;
  logic [4:0] al_f;
  logic [3:0] pl_f;
  logic pre2_f;
  logic crc_f;
  logic dll_on_f;

  // Out-of-range write-termination codes are treated as disabled
  logic wr_en;
  logic nom_en;
  logic park_en;
  logic any_en;

  assign nom_f = mode1_reg[`ODT_NOM_LSB +: 3];
  assign wr_f = mode2_reg[`ODT_WR_LSB +: 3];
  assign park_f = mode5_reg[`ODT_PARK_LSB +: 3];
  assign dll_on_f = mode1_reg[`ODT_DLL_BIT];
  assign cwl_f = lat_reg[`ODT_CWL_LSB +: 5];
  assign al_f = lat_reg[`ODT_AL_LSB +: 5];
  assign pl_f = lat_reg[`ODT_PL_LSB +: 4];
  assign pre2_f = lat_reg[`ODT_PRE2_BIT];
  assign crc_f = lat_reg[`ODT_CRC_BIT];

  assign wr_en = (wr_f != 3'h0) && (wr_f <= 3'h3);
  assign nom_en = nom_f != 3'h0;
  assign park_en = park_f != 3'h0;
  assign any_en = nom_en || wr_en || park_en;

  // One wait cycle per access keeps the answer registered
  assign waitrequest = (read || write) && !ack_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode1_reg <= `ODT_MODE1_RST;
      mode2_reg <= `ODT_MODE2_RST;
      mode5_reg <= `ODT_MODE5_RST;
      lat_reg <= `ODT_LAT_RST;
    end else if (write && !ack_reg) begin
      unique case (address)
        `ODT_OFS_MODE1: begin
          mode1_reg <= merge_bytes(mode1_reg, writedata, byteenable);
        end
        `ODT_OFS_MODE2: begin
          mode2_reg <= merge_bytes(mode2_reg, writedata, byteenable);
        end
        `ODT_OFS_MODE5: begin
          mode5_reg <= merge_bytes(mode5_reg, writedata, byteenable);
        end
        `ODT_OFS_LAT: begin
          lat_reg <= merge_bytes(lat_reg, writedata, byteenable);
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================
  // ODT pin synchroniser and receiver gating
  logic odt_s1_reg;
  logic odt_s2_reg;
  logic odt_s3_reg;
  logic odt_level_reg;
  logic odt_seen;
  logic sync_mode;

  assign sync_mode = dll_on_f && dll_locked;
  assign odt_rx_enable = nom_en && !self_refresh;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      odt_s1_reg <= 1'b0;
      odt_s2_reg <= 1'b0;
      odt_s3_reg <= 1'b0;
      odt_level_reg <= 1'b0;
    end else begin
      odt_s1_reg <= odt_pin;
      odt_s2_reg <= odt_s1_reg;
      odt_s3_reg <= odt_s2_reg;
      if (odt_s2_reg == odt_s3_reg) begin
        odt_level_reg <= odt_s3_reg;
      end
    end
  end

  // A powered-down receiver reads low
  assign odt_seen = odt_level_reg && odt_rx_enable;

  // ========================================================
  // Latency delay of ODT, read and write events
  odt_pkg::latency_t odt_lat;
  logic [5:0] dly_tap;
  logic [2:0] dly_out;
  logic odt_dly;
  logic rd_start;
  logic wr_start;

  // On, off and read-off latencies share one value
  assign odt_lat = wl_minus(cwl_f, al_f, pl_f, pre2_f);
  assign dly_tap = odt_lat - 6'h01;

  odt_delay_line u_delay (
    .clk(clk),
    .reset(reset),
    .din({cmd_write, cmd_read, odt_seen}),
    .tap(dly_tap),
    .dout(dly_out)
  );

  assign odt_dly = dly_out[0];
  assign rd_start = dly_out[1];
  assign wr_start = dly_out[2];

  // Burst chop travels with its command through a shadow bit
  logic chop_rd_reg;
  logic chop_wr_reg;
  logic [63:0] chop_rd_line_reg;
  logic [63:0] chop_wr_line_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chop_rd_line_reg <= 64'h0;
      chop_wr_line_reg <= 64'h0;
      chop_rd_reg <= 1'b0;
      chop_wr_reg <= 1'b0;
    end else begin
      chop_rd_line_reg <= {chop_rd_line_reg[62:0],
                           cmd_read && burst_chop};
      chop_wr_line_reg <= {chop_wr_line_reg[62:0],
                           cmd_write && burst_chop};
      chop_rd_reg <= chop_rd_line_reg[dly_tap];
      chop_wr_reg <= chop_wr_line_reg[dly_tap];
    end
  end

  // ========================================================
  // Window lengths
  logic [3:0] rd_len;
  logic [3:0] wr_len;

  always_comb begin
    if (pre2_f) begin
      rd_len = chop_rd_reg ? `ODT_BC4_PRE2 : `ODT_BL8_PRE2;
    end else begin
      rd_len = chop_rd_reg ? `ODT_BC4_PRE1 : `ODT_BL8_PRE1;
    end
  end

  always_comb begin
    if (crc_f) begin
      wr_len = pre2_f ? `ODT_CRC_PRE2 : `ODT_CRC_PRE1;
    end else if (pre2_f) begin
      wr_len = chop_wr_reg ? `ODT_BC4_PRE2 : `ODT_BL8_PRE2;
    end else begin
      wr_len = chop_wr_reg ? `ODT_BC4_PRE1 : `ODT_BL8_PRE1;
    end
  end

  // ========================================================
  // Read and write windows
  logic [3:0] rd_cnt_reg;
  logic [3:0] wr_cnt_reg;
  logic rd_win;
  logic wr_win;

  // A new command restarts its window, so overlaps extend it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_cnt_reg <= 4'h0;
    end else if (rd_start) begin
      rd_cnt_reg <= rd_len - 4'h1;
    end else if (rd_cnt_reg != 4'h0) begin
      rd_cnt_reg <= rd_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_cnt_reg <= 4'h0;
    end else if (wr_start) begin
      wr_cnt_reg <= wr_len - 4'h1;
    end else if (wr_cnt_reg != 4'h0) begin
      wr_cnt_reg <= wr_cnt_reg - 4'h1;
    end
  end

  assign rd_win = rd_start || (rd_cnt_reg != 4'h0);
  // Dynamic write termination needs the DLL running
  assign wr_win = (wr_start || (wr_cnt_reg != 4'h0)) &&
                  wr_en && sync_mode;

  // ========================================================
  // Termination state choice
  logic nom_req;
  odt_pkg::term_state_e state_next;
  odt_pkg::rtt_code_t code_next;

  // DLL off: ODT is used without the write-latency delay
  assign nom_req = sync_mode ? odt_dly : odt_seen;

  always_comb begin
    state_next = odt_pkg::term_off;
    code_next = 3'h0;
    if (self_refresh || !any_en) begin
      state_next = odt_pkg::term_off;
    end else if (rd_win) begin
      state_next = odt_pkg::term_off;
    end else if (wr_win) begin
      state_next = odt_pkg::term_wr;
      code_next = wr_f;
    end else if (nom_en && nom_req) begin
      state_next = odt_pkg::term_nom;
      code_next = nom_f;
    end else if (park_en) begin
      state_next = odt_pkg::term_park;
      code_next = park_f;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term_state <= odt_pkg::term_off;
      rtt_code <= 3'h0;
      term_hiz <= 1'b1;
    end else begin
      term_state <= state_next;
      rtt_code <= code_next;
      term_hiz <= state_next == odt_pkg::term_off;
    end
  end

  // ========================================================
  // Register read-back
  logic [31:0] status_word;

  assign status_word = {23'h0, wr_win, rd_win, sync_mode,
                        odt_rx_enable, rtt_code, term_state};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h0;
    end else if (read && !ack_reg) begin
      unique case (address)
        `ODT_OFS_MODE1: readdata <= mode1_reg;
        `ODT_OFS_MODE2: readdata <= mode2_reg;
        `ODT_OFS_MODE5: readdata <= mode5_reg;
        `ODT_OFS_LAT: readdata <= lat_reg;
        `ODT_OFS_STATUS: readdata <= status_word;
        default: readdata <= 32'h0;
      endcase
    end
  end

endmodule

// ==== shared/odt_params.svh ====
`ifndef ODT_PARAMS_SVH
`define ODT_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define ODT_OFS_MODE1   5'h00
`define ODT_OFS_MODE2   5'h04
`define ODT_OFS_MODE5   5'h08
`define ODT_OFS_LAT     5'h0C
`define ODT_OFS_STATUS  5'h10

// ==========================================================
// Field positions
`define ODT_NOM_LSB     8
`define ODT_WR_LSB      9
`define ODT_PARK_LSB    6
`define ODT_DLL_BIT     0
`define ODT_CWL_LSB     0
`define ODT_AL_LSB      5
`define ODT_PL_LSB      10
`define ODT_PRE2_BIT    16
`define ODT_CRC_BIT     17

// ==========================================================
// Reset values
`define ODT_MODE1_RST   32'h0000_0001
`define ODT_MODE2_RST   32'h0000_0000
`define ODT_MODE5_RST   32'h0000_0000
`define ODT_LAT_RST     32'h0000_0009

// ==========================================================
// Timing counts in clock cycles
`define ODT_X_PRE1      6'h02
`define ODT_X_PRE2      6'h03
`define ODT_BC4_PRE1    4'h4
`define ODT_BL8_PRE1    4'h6
`define ODT_BC4_PRE2    4'h5
`define ODT_BL8_PRE2    4'h7
`define ODT_CRC_PRE1    4'h7
`define ODT_CRC_PRE2    4'h8
`define ODT_DLY_DEPTH   64

`endif

// ==== shared/odt_pkg.sv ====
package odt_pkg;

  // Termination state, listed from highest to lowest priority
  typedef enum logic [1:0] {
    term_off,
    term_wr,
    term_nom,
    term_park
  } term_state_e;

  typedef logic [2:0] rtt_code_t;
  typedef logic [5:0] latency_t;

endpackage

// ==== rtl/odt_delay_line.sv ====
`timescale 1ns/10ps
`include "odt_params.svh"

// ==========================================================
// Tapped delay line; the tapped value comes out of a register,
// so a tap of n gives a total delay of n + 2 cycles.
module odt_delay_line (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] din,
  input wire logic [5:0] tap,
  output logic [2:0] dout
);

  logic [2:0] line_reg [0:`ODT_DLY_DEPTH-1];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `ODT_DLY_DEPTH; i++) begin
        line_reg[i] <= 3'h0;
      end
    end else begin
      line_reg[0] <= din;
      for (int i = 1; i < `ODT_DLY_DEPTH; i++) begin
        line_reg[i] <= line_reg[i-1];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dout <= 3'h0;
    end else begin
      dout <= line_reg[tap];
    end
  end

endmodule

// ==== test/odt_termination_control_monitor.sv ====
`timescale 1ns/10ps
module odt_termination_control_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic cmd_read,
  input wire logic self_refresh,
  input odt_pkg::term_state_e term_state,
  input odt_pkg::rtt_code_t rtt_code,
  input wire logic term_hiz,
  input wire logic odt_rx_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence req_s;
    (read || write) && waitrequest;
  endsequence
  sequence rd_off_s;
    (term_state == odt_pkg::term_off) [*4];
  endsequence
  sequence wr_kept_s;
    (term_state inside {odt_pkg::term_off, odt_pkg::term_wr}) [*4];
  endsequence
  // ==========
  // Bus and state coding
  a_one_wait: assert property (req_s |=> !waitrequest)
    else $error("bus answer late");
  a_hiz_off: assert property (
    term_hiz == (term_state == odt_pkg::term_off))
    else $error("hiz flag wrong");
  a_off_code: assert property (
    (term_state == odt_pkg::term_off) == (rtt_code == 3'h0))
    else $error("code and state disagree");
  a_wr_code: assert property (
    term_state == odt_pkg::term_wr |-> rtt_code inside {3'h1, 3'h2, 3'h3})
    else $error("bad write code");
  // ==========
  // Windows and self-refresh
  a_read_off: assert property (
    cmd_read && !self_refresh |-> ##[2:66] rd_off_s)
    else $error("read window missing");
  a_write_kept: assert property (
    $changed(term_state) && term_state == odt_pkg::term_wr |-> wr_kept_s)
    else $error("write window cut short");
  a_sref_off: assert property (
    $past(self_refresh) |-> term_state == odt_pkg::term_off)
    else $error("termination in self-refresh");
  a_sref_rx: assert property (self_refresh |-> !odt_rx_enable)
    else $error("receiver on in self-refresh");
endmodule

bind odt_termination_control odt_termination_control_monitor mon (
  .clk, .reset, .read, .write, .waitrequest, .cmd_read, .self_refresh,
  .term_state, .rtt_code, .term_hiz, .odt_rx_enable);

// ==== test/odt_ctrl_model.sv ====
`timescale 1ns/10ps
module odt_ctrl_model #(
  parameter int ODTH_MIN = 7
) (
  input wire logic clk,
  output logic odt_pin,
  output logic cmd_read,
  output logic cmd_write,
  output logic burst_chop,
  output logic self_refresh,
  output logic dll_locked
);
  initial begin
    odt_pin = 1'b0;
    cmd_read = 1'b0;
    cmd_write = 1'b0;
    burst_chop = 1'b0;
    self_refresh = 1'b0;
    dll_locked = 1'b1;
  end
  // ==========
  // Commands are one-cycle pulses
  task automatic issue(input logic rd, input logic bc4);
    @(posedge clk);
    cmd_read <= rd;
    cmd_write <= !rd;
    burst_chop <= bc4;
    @(posedge clk);
    cmd_read <= 1'b0;
    cmd_write <= 1'b0;
    // Chop is meaningless between commands, so show the other level
    burst_chop <= !bc4;
  endtask
  task automatic odt(input logic v, input int n);
    @(posedge clk);
    odt_pin <= v;
    // A raised ODT is kept at least the minimum hold
    repeat ((v && n < ODTH_MIN) ? ODTH_MIN : n) @(posedge clk);
    #1;
  endtask
  task automatic sref(input logic v);
    @(posedge clk);
    self_refresh <= v;
  endtask
  task automatic dll(input logic v);
    @(posedge clk);
    dll_locked <= v;
  endtask
endmodule

// ==== test/test_odt_termination_control.sv ====
`timescale 1ns/10ps
module test_odt_termination_control;
  logic clk, reset, read, write, waitrequest, term_hiz, odt_rx_enable;
  logic odt_pin, cmd_read, cmd_write, burst_chop, self_refresh, dll_locked;
  logic [4:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [2:0] ec;
  odt_pkg::term_state_e term_state, es;
  odt_pkg::rtt_code_t rtt_code;
  int err_total, num_checks, cyc, n;
  odt_termination_control dut (.clk, .reset, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .odt_pin, .cmd_read,
    .cmd_write, .burst_chop, .self_refresh, .dll_locked, .term_state,
    .rtt_code, .term_hiz, .odt_rx_enable);
  odt_ctrl_model ctl (.clk, .odt_pin, .cmd_read, .cmd_write, .burst_chop,
    .self_refresh, .dll_locked);
  task automatic end_of_test;
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic st(input odt_pkg::term_state_e s, input logic [2:0] c);
    chk(32'({term_hiz, rtt_code, term_state}),
      32'({s == odt_pkg::term_off, c, s}));
  endtask
  task automatic pk;
    st(odt_pkg::term_park, 3'h5);
  endtask
  // ==========
  // Bus access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // Sample at the edge itself, before the slave's own updates land
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Run needs about 340 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    wt(1);
    st(odt_pkg::term_off, 3'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0);
      chk(q, i == 0 ? 32'h1 : i == 3 ? 32'h9 : 32'h0);
    end
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 5'h00, 32'h0000_0301);
    bus(1'b1, 5'h04, 32'h0000_0400);
    bus(1'b1, 5'h08, 32'h0000_0140);
    wt(3);
    pk();
    // Read and write windows for each preamble and burst length
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 5'h0C, {15'h0, i[0], 16'h0009});
      n = (i[1] ? 4 : 6) + i[0];
      es = i[2] ? odt_pkg::term_off : odt_pkg::term_wr;
      ec = i[2] ? 3'h0 : 3'h2;
      ctl.issue(i[2], i[1]);
      wt(7 - i[0]);
      pk();
      wt(1);
      st(es, ec);
      wt(n - 1);
      st(es, ec);
      wt(1);
      pk();
    end
    bus(1'b1, 5'h0C, 32'h0000_0009);
    ctl.odt(1'b1, 9);
    pk();
    wt(6);
    st(odt_pkg::term_nom, 3'h3);
    bus(1'b1, 5'h10, 32'h0);
    bus(1'b0, 5'h10, 32'h0);
    chk(q, 32'h0000_006E);
    ctl.issue(1'b0, 1'b0);
    wt(8);
    st(odt_pkg::term_wr, 3'h2);
    ctl.odt(1'b0, 15);
    pk();
    ctl.odt(1'b1, 16);
    ctl.sref(1'b1);
    wt(2);
    st(odt_pkg::term_off, 3'h0);
    chk(32'(odt_rx_enable), 32'h0);
    ctl.sref(1'b0);
    bus(1'b1, 5'h00, 32'h0000_0001);
    wt(12);
    chk(32'(odt_rx_enable), 32'h0);
    pk();
    bus(1'b1, 5'h08, 32'h0);
    wt(2);
    st(odt_pkg::term_off, 3'h0);
    bus(1'b1, 5'h08, 32'h0000_0140);
    bus(1'b1, 5'h00, 32'h0000_0300);
    wt(8);
    st(odt_pkg::term_nom, 3'h3);
    ctl.odt(1'b0, 7);
    pk();
    // CRC stretches a chopped write window to seven cycles
    bus(1'b1, 5'h00, 32'h0000_0301);
    bus(1'b1, 5'h0C, 32'h0002_0009);
    ctl.issue(1'b0, 1'b1);
    wt(7);
    pk();
    wt(1);
    st(odt_pkg::term_wr, 3'h2);
    wt(6);
    st(odt_pkg::term_wr, 3'h2);
    wt(1);
    pk();
    // DLL enabled but unlocked: no write termination, no ODT latency
    ctl.dll(1'b0);
    ctl.issue(1'b0, 1'b0);
    wt(8);
    pk();
    ctl.odt(1'b1, 7);
    st(odt_pkg::term_nom, 3'h3);
    end_of_test;
  end
endmodule
